// File: alu_if.sv
/*
  Carrier between the sequencer and the arithmetic unit.
  Assumes both ends run in the same clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
interface alu_if;
  cpu_slice_pkg::alu_op_type op;
  logic [7:0]                a;
  logic [7:0]                b;
  logic                      cin;
  logic [7:0]                res;
  logic [4:0]                flags;

  modport seq (output op, output a, output b, output cin, input res, input flags);
  modport unit (input op, input a, input b, input cin, output res, output flags);
endinterface
`default_nettype wire

// File: cpu_slice_exec.sv
/*
  Execution sequencer for subtract, swap, test-skip, XOR literal and table ops.
  Assumes instructions arrive from fetch on the core clock, a register file that
  answers within one phase, and program memory that answers within one phase.
*/
`timescale 1ns/1ns
`default_nettype none
module cpu_slice_exec (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic        next_two_word,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic [11:0] index_base,
  input  wire logic [7:0]  file_rdata,
  input  wire logic [15:0] pm_rdata,
  input  wire logic        ptr_wr,
  input  wire logic [20:0] ptr_wdata,
  input  wire logic        latch_wr,
  input  wire logic [7:0]  latch_wdata,
  input  wire logic        cfg_programmed,
  input  wire logic        extended_set_config_bit,
  output logic [1:0]       phase,
  output logic             busy,
  output logic             flush,
  output logic [7:0]       working,
  output logic [4:0]       status,
  output logic [11:0]      file_addr,
  output logic [7:0]       file_wdata,
  output logic             file_we,
  output logic [20:0]      table_pointer,
  output logic [7:0]       table_latch,
  output logic [63:0]      holding_flat
);
  cpu_slice_pkg::state_type state_q, state_d;
  logic [1:0]  phase_q, phase_d;
  logic        act_q, act_d;
  logic        skip2_q, skip2_d;
  logic [15:0] opc_q, opc_d;
  logic [7:0]  opnd_q, opnd_d;
  logic [7:0]  res_q, res_d;
  logic [4:0]  flg_q, flg_d;
  logic [7:0]  w_q, w_d;
  logic [4:0]  status_q, status_d;
  logic [11:0] faddr_q, faddr_d;
  logic [7:0]  fwdata_q, fwdata_d;
  logic        fwe_q, fwe_d;
  logic [20:0] ptr_q, ptr_d;
  logic [7:0]  latch_q, latch_d;
  logic [7:0]  hold_q [0:7];
  logic [7:0]  hold_d [0:7];
  logic        flush_q, flush_d;
  logic        busy_q, busy_d;
  logic [1:0]  cfg_prog_s1, cfg_prog_s2, cfg_bit_s1, cfg_bit_s2;
  logic        ext_en_q, ext_en_d;
  logic        is_subb, is_subw, is_swap, is_tst, is_subl, is_xorl, is_table_read_op, is_table_write_op;
  logic        to_file;
  logic [4:0]  mask;
  logic [7:0]  pm_byte;
  alu_if       alu ();

  slice_alu u_alu (
    .u (alu.unit)
  );

  always_comb begin
    is_subb = (opc_q[15:10] == cpu_slice_pkg::SUBB_PAT);
    is_subw = (opc_q[15:10] == cpu_slice_pkg::SUBW_PAT);
    is_swap = (opc_q[15:10] == cpu_slice_pkg::SWAP_PAT);
    is_tst = (opc_q[15:9] == cpu_slice_pkg::TST_PAT);
    is_subl = (opc_q[15:8] == cpu_slice_pkg::SUBL_PAT);
    is_xorl = (opc_q[15:8] == cpu_slice_pkg::XORL_PAT);
    is_table_read_op = (opc_q[15:2] == cpu_slice_pkg::TABLE_READ_OP_PAT);
    is_table_write_op = (opc_q[15:2] == cpu_slice_pkg::TABLE_WRITE_OP_PAT);
    to_file = opc_q[cpu_slice_pkg::BIT_D] && (is_subb || is_subw || is_swap);
    if (is_subb || is_subw || is_subl) begin
      mask = cpu_slice_pkg::MASK_SUB;
    end else if (is_xorl) begin
      mask = cpu_slice_pkg::MASK_NZ;
    end else begin
      mask = cpu_slice_pkg::MASK_NONE;
    end
    pm_byte = ptr_q[0] ? pm_rdata[15:8] : pm_rdata[7:0];
    alu.a = opnd_q;
    alu.b = w_q;
    alu.cin = 1'b1;
    if (is_subb) begin
      alu.op = cpu_slice_pkg::ALU_SUBB;
      alu.cin = status_q[cpu_slice_pkg::ST_C];
    end else if (is_subw) begin
      alu.op = cpu_slice_pkg::ALU_SUBW;
    end else if (is_subl) begin
      alu.op = cpu_slice_pkg::ALU_SUBL;
    end else if (is_swap) begin
      alu.op = cpu_slice_pkg::ALU_SWAP;
    end else if (is_xorl) begin
      alu.op = cpu_slice_pkg::ALU_XOR;
      alu.a = w_q;
      alu.b = opnd_q;
    end else begin
      alu.op = cpu_slice_pkg::ALU_PASS;
    end
  end

  always_comb begin
    state_d = state_q;
    phase_d = phase_q + cpu_slice_pkg::PH_STEP;
    act_d = act_q;
    skip2_d = skip2_q;
    opc_d = opc_q;
    opnd_d = opnd_q;
    res_d = res_q;
    flg_d = flg_q;
    w_d = w_q;
    status_d = status_q;
    faddr_d = faddr_q;
    fwdata_d = fwdata_q;
    fwe_d = 1'b0;
    ptr_d = ptr_q;
    latch_d = latch_q;
    hold_d = hold_q;
    flush_d = 1'b0;
    // An unprogrammed part keeps the extension on.
    ext_en_d = cfg_prog_s2[1] ? cfg_bit_s2[1] : 1'b1;
    case (state_q)
      cpu_slice_pkg::ST_EXEC: begin
        case (phase_q)
          cpu_slice_pkg::PH_Q1: begin
            act_d = instr_valid;
            opc_d = instr_word;
            if (!instr_word[cpu_slice_pkg::BIT_A]) begin
              if (ext_en_q && instr_word[7:0] <= cpu_slice_pkg::INDEX_LIMIT) begin
                faddr_d = index_base + {4'h0, instr_word[7:0]};
              end else if (instr_word[7:0] <= cpu_slice_pkg::INDEX_LIMIT) begin
                faddr_d = {cpu_slice_pkg::ACC_LOW_BANK, instr_word[7:0]};
              end else begin
                faddr_d = {cpu_slice_pkg::ACC_HIGH_BANK, instr_word[7:0]};
              end
            end else begin
              faddr_d = {bank_select_register, instr_word[7:0]};
            end
          end
          cpu_slice_pkg::PH_Q2: begin
            opnd_d = (is_subl || is_xorl) ? opc_q[7:0] : file_rdata;
          end
          cpu_slice_pkg::PH_Q3: begin
            res_d = alu.res;
            flg_d = alu.flags;
            fwdata_d = alu.res;
            fwe_d = act_q && to_file;
          end
          default: begin
            if (act_q) begin
              status_d = (status_q & ~mask) | (flg_q & mask);
              if (!to_file && (is_subb || is_subw || is_swap || is_subl || is_xorl)) begin
                w_d = res_q;
              end
              if (is_tst && opnd_q == cpu_slice_pkg::BYTE_ZERO) begin
                state_d = cpu_slice_pkg::ST_NOP;
                flush_d = 1'b1;
                skip2_d = next_two_word;
              end
              if (is_table_read_op || is_table_write_op) begin
                state_d = cpu_slice_pkg::ST_TBL;
                if (opc_q[1:0] == cpu_slice_pkg::MODE_PRE_INC) begin
                  ptr_d = ptr_q + cpu_slice_pkg::PTR_ONE;
                end
              end
            end
            act_d = 1'b0;
          end
        endcase
      end
      cpu_slice_pkg::ST_TBL: begin
        if (phase_q == cpu_slice_pkg::PH_Q4) begin
          if (is_table_read_op) begin
            latch_d = pm_byte;
          end else begin
            hold_d[ptr_q[2:0]] = latch_q;
          end
          if (opc_q[1:0] == cpu_slice_pkg::MODE_POST_INC) begin
            ptr_d = ptr_q + cpu_slice_pkg::PTR_ONE;
          end else if (opc_q[1:0] == cpu_slice_pkg::MODE_POST_DEC) begin
            ptr_d = ptr_q - cpu_slice_pkg::PTR_ONE;
          end
          state_d = cpu_slice_pkg::ST_EXEC;
        end
      end
      cpu_slice_pkg::ST_NOP: begin
        if (phase_q == cpu_slice_pkg::PH_Q4) begin
          state_d = skip2_q ? cpu_slice_pkg::ST_NOP2 : cpu_slice_pkg::ST_EXEC;
          flush_d = skip2_q;
          skip2_d = 1'b0;
        end
      end
      cpu_slice_pkg::ST_NOP2: begin
        if (phase_q == cpu_slice_pkg::PH_Q4) begin
          state_d = cpu_slice_pkg::ST_EXEC;
        end
      end
      default: begin
        state_d = cpu_slice_pkg::ST_EXEC;
      end
    endcase
    // Software loads of the pointer and latch take priority over instruction updates.
    if (ptr_wr) begin
      ptr_d = ptr_wdata;
    end
    if (latch_wr) begin
      latch_d = latch_wdata;
    end
    busy_d = (state_d != cpu_slice_pkg::ST_EXEC);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_prog_s1 <= 2'h0;
      cfg_prog_s2 <= 2'h0;
      cfg_bit_s1 <= 2'h0;
      cfg_bit_s2 <= 2'h0;
    end else if (clk_en) begin
      cfg_prog_s1 <= {cfg_prog_s1[0], cfg_programmed};
      cfg_bit_s1 <= {cfg_bit_s1[0], extended_set_config_bit};
      cfg_prog_s2 <= cfg_prog_s1;
      cfg_bit_s2 <= cfg_bit_s1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= cpu_slice_pkg::ST_EXEC;
      phase_q <= cpu_slice_pkg::PH_Q1;
      act_q <= 1'b0;
      skip2_q <= 1'b0;
      opc_q <= 16'h0000;
      opnd_q <= cpu_slice_pkg::BYTE_ZERO;
      res_q <= cpu_slice_pkg::BYTE_ZERO;
      flg_q <= cpu_slice_pkg::STATUS_RST;
      w_q <= cpu_slice_pkg::W_RST;
      status_q <= cpu_slice_pkg::STATUS_RST;
      faddr_q <= cpu_slice_pkg::ADDR_RST;
      fwdata_q <= cpu_slice_pkg::BYTE_ZERO;
      fwe_q <= 1'b0;
      ptr_q <= cpu_slice_pkg::PTR_RST;
      latch_q <= cpu_slice_pkg::BYTE_ZERO;
      for (int i = 0; i < cpu_slice_pkg::HOLD_NUM; i++) begin
        hold_q[i] <= cpu_slice_pkg::BYTE_ZERO;
      end
      flush_q <= 1'b0;
      busy_q <= 1'b0;
      ext_en_q <= 1'b1;
    end else if (clk_en) begin
      state_q <= state_d;
      phase_q <= phase_d;
      act_q <= act_d;
      skip2_q <= skip2_d;
      opc_q <= opc_d;
      opnd_q <= opnd_d;
      res_q <= res_d;
      flg_q <= flg_d;
      w_q <= w_d;
      status_q <= status_d;
      faddr_q <= faddr_d;
      fwdata_q <= fwdata_d;
      fwe_q <= fwe_d;
      ptr_q <= ptr_d;
      latch_q <= latch_d;
      hold_q <= hold_d;
      flush_q <= flush_d;
      busy_q <= busy_d;
      ext_en_q <= ext_en_d;
    end
  end

  for (genvar g = 0; g < cpu_slice_pkg::HOLD_NUM; g++) begin : g_hold
    assign holding_flat[g*8 +: 8] = hold_q[g];
  end

  assign phase = phase_q;
  assign busy = busy_q;
  assign flush = flush_q;
  assign working = w_q;
  assign status = status_q;
  assign file_addr = faddr_q;
  assign file_wdata = fwdata_q;
  assign file_we = fwe_q;
  assign table_pointer = ptr_q;
  assign table_latch = latch_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_PHASE_STEP: assert property (clk_en |=> phase_q == $past(phase_q) + 2'h1)
    else $error("phase did not advance");
  AST_SUBB_VALUE: assert property (clk_en && is_subb
      && state_q == cpu_slice_pkg::ST_EXEC && phase_q == cpu_slice_pkg::PH_Q3
      |=> res_q == 8'(opnd_q - w_q - {7'h00, ~status_q[cpu_slice_pkg::ST_C]}))
    else $error("subtract with borrow result wrong");
  // A borrow gives the two's complement difference, carry clear and N as its sign bit.
  AST_NEG_FLAGS: assert property (clk_en && act_q && is_subw && opnd_q < w_q
      && phase_q == cpu_slice_pkg::PH_Q3 |=> !flg_q[cpu_slice_pkg::ST_C]
      && res_q == 8'(opnd_q - w_q) && flg_q[cpu_slice_pkg::ST_N] == res_q[7])
    else $error("negative result flags wrong");
  AST_SWAP_KEEP: assert property (clk_en && act_q && is_swap
      && phase_q == cpu_slice_pkg::PH_Q4 |=> $stable(status_q))
    else $error("swap changed status");
  AST_DEST_W: assert property (clk_en && act_q && is_xorl
      && phase_q == cpu_slice_pkg::PH_Q4 |=> w_q == $past(res_q)
      && status_q[cpu_slice_pkg::ST_C] == $past(status_q[cpu_slice_pkg::ST_C]))
    else $error("xor literal write wrong");
  AST_INDEXED: assert property (clk_en && ext_en_q
      && !instr_word[cpu_slice_pkg::BIT_A] && instr_word[7:0] <= cpu_slice_pkg::INDEX_LIMIT
      && state_q == cpu_slice_pkg::ST_EXEC && phase_q == cpu_slice_pkg::PH_Q1
      |=> faddr_q == $past(index_base) + {4'h0, $past(instr_word[7:0])})
    else $error("indexed address wrong");
  AST_SKIP_FLUSH: assert property (flush_q && state_q == cpu_slice_pkg::ST_NOP
      |-> phase_q == cpu_slice_pkg::PH_Q1 && busy_q)
    else $error("skip did not enter flush");
  AST_TABLE_READ_OP_LATCH: assert property (clk_en && is_table_read_op && !latch_wr
      && state_q == cpu_slice_pkg::ST_TBL && phase_q == cpu_slice_pkg::PH_Q4
      |=> latch_q == $past(pm_byte))
    else $error("table read latch wrong");
  AST_TABLE_WRITE_OP_HOLD: assert property (clk_en && is_table_write_op
      && state_q == cpu_slice_pkg::ST_TBL && phase_q == cpu_slice_pkg::PH_Q4
      |=> hold_q[$past(ptr_q[2:0])] == $past(latch_q))
    else $error("holding register write wrong");
endmodule // cpu_slice_exec
`default_nettype wire

// File: cpu_slice_exec_tb.sv
/*
  Self-checking testbench for the subtract, swap, test-skip, XOR literal and table slice.
  Assumes the execution sequencer timing of one instruction every four clocks.
*/
`timescale 1ns/1ns
`default_nettype none
module cpu_slice_exec_tb;
  logic        clk;
  logic        rstn;
  logic        clk_en;
  logic        instr_valid;
  logic [15:0] instr_word;
  logic        next_two_word;
  logic [3:0]  bank_select_register;
  logic [11:0] index_base;
  logic [7:0]  file_rdata;
  logic [15:0] pm_rdata;
  logic        ptr_wr;
  logic [20:0] ptr_wdata;
  logic        latch_wr;
  logic [7:0]  latch_wdata;
  logic        cfg_programmed;
  logic        extended_set_config_bit;
  logic [1:0]  phase;
  logic        busy;
  logic        flush;
  logic [7:0]  working;
  logic [4:0]  status;
  logic [11:0] file_addr;
  logic [7:0]  file_wdata;
  logic        file_we;
  logic [20:0] table_pointer;
  logic [7:0]  table_latch;
  logic [63:0] holding_flat;
  int          n_fail;
  int          checked;
  logic [7:0]  m_w;
  logic [4:0]  m_st;
  logic [63:0] m_hold;
  logic        ext;

  cpu_slice_exec DUT (.clk(clk), .rstn(rstn), .clk_en(clk_en), .instr_valid(instr_valid),
    .instr_word(instr_word), .next_two_word(next_two_word),
    .bank_select_register(bank_select_register), .index_base(index_base),
    .file_rdata(file_rdata), .pm_rdata(pm_rdata), .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata),
    .latch_wr(latch_wr), .latch_wdata(latch_wdata), .cfg_programmed(cfg_programmed),
    .extended_set_config_bit(extended_set_config_bit), .phase(phase), .busy(busy),
    .flush(flush), .working(working), .status(status), .file_addr(file_addr),
    .file_wdata(file_wdata), .file_we(file_we), .table_pointer(table_pointer),
    .table_latch(table_latch), .holding_flat(holding_flat));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  task automatic final_report();
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Result and flags {N,OV,Z,DC,C} of x minus y minus the inverted carry in.
  function automatic logic [12:0] subf(input logic [7:0] x, input logic [7:0] y,
                                       input logic cin);
    logic [8:0] s;
    logic [4:0] l;
    s = {1'b0, x} + {1'b0, ~y} + 9'(cin);
    l = {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + 5'(cin);
    return {s[7:0], s[7], (x[7] != y[7]) && (s[7] != x[7]), s[7:0] == 8'h00, l[4], s[8]};
  endfunction

  // Issues one instruction when the sequencer is idle and watches nw falling edges.
  task automatic go(input logic [15:0] ins, input int nw, output int we_n,
                    output logic [7:0] we_d, output int bn, output int fn,
                    output logic [11:0] ad);
    int g;
    g = 0;
    we_n = 0;
    bn = 0;
    fn = 0;
    we_d = 8'h00;
    while (!(phase === 2'h0 && busy === 1'b0) && g < 50) begin
      @(negedge clk);
      g++;
    end
    instr_valid = 1'b1;
    instr_word = ins;
    for (int i = 1; i <= nw; i++) begin
      @(negedge clk);
      if (i == 1) ad = file_addr;
      if (file_we === 1'b1) begin
        we_n++;
        we_d = file_wdata;
      end
      bn += (busy === 1'b1);
      fn += (flush === 1'b1);
      // Requests offered while busy must be ignored; none stands when the call returns.
      if (i < nw) begin
        instr_valid = (busy === 1'b1) && (phase !== 2'h3);
        instr_word = {cpu_slice_pkg::XORL_PAT, 8'hFF};
      end
    end
    chk({busy, phase}, 3'h0);
  endtask

  task automatic byte_op(input int kind);
    logic [7:0]  f;
    logic [7:0]  fd;
    logic [7:0]  k;
    logic        d;
    logic        a;
    logic [12:0] r;
    logic [11:0] ea;
    logic [11:0] ad;
    logic [15:0] ins;
    logic [7:0]  we_d;
    int          we_n, bn, fn, skip;
    f = ($urandom % 4 == 0) ? 8'(8'h5F + $urandom % 2) : 8'($urandom);
    fd = ($urandom % 4 == 0) ? 8'h00 : 8'($urandom);
    k = 8'($urandom);
    d = 1'($urandom);
    a = 1'($urandom);
    bank_select_register = 4'($urandom);
    index_base = 12'($urandom);
    file_rdata = fd;
    next_two_word = 1'($urandom);
    case (kind)
      0: ins = {cpu_slice_pkg::SUBB_PAT, d, a, f};
      1: ins = {cpu_slice_pkg::SUBW_PAT, d, a, f};
      2: ins = {cpu_slice_pkg::SWAP_PAT, d, a, f};
      3: ins = {cpu_slice_pkg::TST_PAT, a, f};
      4: ins = {cpu_slice_pkg::XORL_PAT, k};
      default: ins = {cpu_slice_pkg::SUBL_PAT, k};
    endcase
    case (kind)
      0: r = subf(fd, m_w, m_st[0]);
      1: r = subf(fd, m_w, 1'b1);
      2: r = {fd[3:0], fd[7:4], m_st};
      4: r = {m_w ^ k, m_w[7] ^ k[7], m_st[3], (m_w ^ k) == 8'h00, m_st[1:0]};
      5: r = subf(k, m_w, 1'b1);
      default: r = {8'h00, m_st};
    endcase
    skip = (kind == 3 && fd == 8'h00) ? (next_two_word ? 2 : 1) : 0;
    go(ins, 4 + 4 * skip, we_n, we_d, bn, fn, ad);
    if (kind >= 4 || (kind < 3 && !d)) m_w = r[12:5];
    if (kind != 2 && kind != 3) m_st = r[4:0];
    if (a) ea = {bank_select_register, f};
    else if (f <= cpu_slice_pkg::INDEX_LIMIT) ea = ext ? 12'(index_base + 12'(f)) : {4'h0, f};
    else ea = {4'hF, f};
    chk(working, m_w);
    chk(status, m_st);
    chk(we_n, (kind < 3 && d) ? 1 : 0);
    if (kind < 3 && d) chk(we_d, r[12:5]);
    if (kind < 4) chk(ad, ea);
    chk(fn, skip);
    chk(bn, 4 * skip);
  endtask

  task automatic tbl(input logic wr, input logic [1:0] m);
    logic [20:0] p;
    logic [20:0] pu;
    logic [20:0] pe;
    logic [15:0] pm;
    logic [7:0]  lt;
    logic [7:0]  we_d;
    logic [11:0] ad;
    int          we_n, bn, fn;
    p = ($urandom % 4 == 0) ? (($urandom % 2) ? 21'h1FFFFF : 21'h000000) : 21'($urandom);
    pm = 16'($urandom);
    lt = 8'($urandom);
    pm_rdata = pm;
    @(negedge clk);
    ptr_wr = 1'b1;
    ptr_wdata = p;
    latch_wr = 1'b1;
    latch_wdata = lt;
    @(negedge clk);
    ptr_wr = 1'b0;
    latch_wr = 1'b0;
    pu = (m == cpu_slice_pkg::MODE_PRE_INC) ? p + 21'h1 : p;
    go({wr ? cpu_slice_pkg::TABLE_WRITE_OP_PAT : cpu_slice_pkg::TABLE_READ_OP_PAT, m}, 8, we_n, we_d, bn, fn, ad);
    if (wr) m_hold[8 * pu[2:0] +: 8] = lt;
    chk(holding_flat, m_hold);
    chk(table_latch, wr ? lt : (pu[0] ? pm[15:8] : pm[7:0]));
    pe = (m == cpu_slice_pkg::MODE_POST_DEC) ? p - 21'h1 :
         (m == cpu_slice_pkg::MODE_POST_INC) ? p + 21'h1 : pu;
    chk(table_pointer, pe);
    chk(bn, 4);
    chk(we_n, 0);
  endtask

  initial begin
    n_fail = 0;
    checked = 0;
    rstn = 1'b0;
    clk_en = 1'b1;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    next_two_word = 1'b0;
    bank_select_register = 4'h0;
    index_base = 12'h000;
    file_rdata = 8'h00;
    pm_rdata = 16'h0000;
    ptr_wr = 1'b0;
    ptr_wdata = 21'h000000;
    latch_wr = 1'b0;
    latch_wdata = 8'h00;
    cfg_programmed = 1'b0;
    extended_set_config_bit = 1'b0;
    m_w = 8'h00;
    m_st = 5'h00;
    m_hold = 64'h0;
    void'($urandom(79818));
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    chk({working, status, table_pointer, table_latch}, 64'h0);
    chk(holding_flat, 64'h0);
    for (int c = 0; c < 3; c++) begin
      cfg_programmed = (c != 0);
      extended_set_config_bit = (c == 2);
      ext = (c != 1);
      // A reset in mid-run must bring every register back to its idle value.
      if (c == 1) begin
        rstn = 1'b0;
        @(negedge clk);
        rstn = 1'b1;
        m_w = 8'h00;
        m_st = 5'h00;
        m_hold = 64'h0;
        chk({busy, phase, working, status, table_pointer, table_latch}, 45'h0);
        chk(holding_flat, 64'h0);
      end
      repeat (4) @(negedge clk);
      for (int n = 0; n < 60; n++) begin
        int s;
        s = $urandom % 8;
        if (s < 6) byte_op(s);
        else tbl(s == 7, 2'($urandom));
        // A low clock enable must freeze the phase counter and all results.
        if ($urandom % 8 == 0) begin
          clk_en = 1'b0;
          repeat (3) @(negedge clk);
          chk({busy, phase, working, status}, {3'h0, m_w, m_st});
          clk_en = 1'b1;
        end
      end
    end
    final_report();
  end

  initial begin
    #100000;
    n_fail++;
    final_report();
  end
endmodule // cpu_slice_exec_tb
`default_nettype wire

// File: cpu_slice_pkg.sv
/*
  Constants, opcode patterns and types for the arithmetic, swap, skip and table slice.
  Assumes a single core clock with four clocks to one instruction cycle.
*/
// How it works
// - Subtract with borrow yields file minus working minus inverted carry.
// - A negative difference gives two's complement, carry cleared, negative taken from bit 7.
// - Nibble swap exchanges the two halves of the byte and keeps all flags.
// - Destination bit zero writes the working register, one writes the file.
// - Access bit zero uses the access bank, one uses the bank select register.
// - Extended set, access bit zero and address up to 5Fh use index offset.
// - Test skip on zero discards the fetched next instruction, two cycles.
// - Skipping a two-word instruction costs three cycles in total.
// - XOR literal updates the working register and only negative and zero.
// - The table pointer is a 21-bit byte address into program memory.
// - Pointer bit 0 selects low byte (0) or high byte (1) of a word.
// - Mode 0 keeps, 1 post-increments, 2 post-decrements, 3 pre-increments.
// - Table read takes two cycles, latching the byte at the second's end.
// - Table write copies the latch into holding register pointer bits 2..0.
// - Eight holding registers stage the bytes later programmed into memory.
// - Extended set follows a configuration bit, enabled when unprogrammed.
package cpu_slice_pkg;
  localparam logic [1:0]  PH_Q1 = 2'h0;
  localparam logic [1:0]  PH_Q2 = 2'h1;
  localparam logic [1:0]  PH_Q3 = 2'h2;
  localparam logic [1:0]  PH_Q4 = 2'h3;
  localparam logic [1:0]  PH_STEP = 2'h1;
  localparam logic [5:0]  SUBB_PAT = 6'h16;
  localparam logic [5:0]  SUBW_PAT = 6'h17;
  localparam logic [5:0]  SWAP_PAT = 6'h0E;
  localparam logic [6:0]  TST_PAT = 7'h33;
  localparam logic [7:0]  SUBL_PAT = 8'h08;
  localparam logic [7:0]  XORL_PAT = 8'h0A;
  localparam logic [13:0] TABLE_READ_OP_PAT = 14'h0002;
  localparam logic [13:0] TABLE_WRITE_OP_PAT = 14'h0003;
  localparam int unsigned BIT_D = 9;
  localparam int unsigned BIT_A = 8;
  localparam logic [7:0]  INDEX_LIMIT = 8'h5F;
  localparam logic [3:0]  ACC_LOW_BANK = 4'h0;
  localparam logic [3:0]  ACC_HIGH_BANK = 4'hF;
  localparam logic [1:0]  MODE_KEEP = 2'h0;
  localparam logic [1:0]  MODE_POST_INC = 2'h1;
  localparam logic [1:0]  MODE_POST_DEC = 2'h2;
  localparam logic [1:0]  MODE_PRE_INC = 2'h3;
  localparam int unsigned ST_C = 0;
  localparam int unsigned ST_DC = 1;
  localparam int unsigned ST_Z = 2;
  localparam int unsigned ST_OV = 3;
  localparam int unsigned ST_N = 4;
  localparam logic [4:0]  MASK_SUB = 5'h1F;
  localparam logic [4:0]  MASK_NZ = 5'h14;
  localparam logic [4:0]  MASK_NONE = 5'h00;
  localparam logic [4:0]  STATUS_RST = 5'h00;
  localparam logic [7:0]  W_RST = 8'h00;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [20:0] PTR_RST = 21'h000000;
  localparam logic [20:0] PTR_ONE = 21'h000001;
  localparam logic [11:0] ADDR_RST = 12'h000;
  localparam int unsigned HOLD_NUM = 8;

  typedef enum logic [2:0] {
    ALU_SUBB = 3'h0,
    ALU_SUBW = 3'h1,
    ALU_SUBL = 3'h2,
    ALU_SWAP = 3'h3,
    ALU_XOR  = 3'h4,
    ALU_PASS = 3'h5
  } alu_op_type;

  typedef enum logic [3:0] {
    ST_EXEC = 4'b0001,
    ST_TBL  = 4'b0010,
    ST_NOP  = 4'b0100,
    ST_NOP2 = 4'b1000
  } state_type;
endpackage

// File: slice_alu.sv
/*
  Combinational arithmetic unit: subtract forms, nibble swap, XOR and pass.
  Assumes the sequencer registers everything it takes from here.
*/
`timescale 1ns/1ns
`default_nettype none
module slice_alu (
  alu_if.unit u
);
  logic [8:0] diff;
  logic [4:0] low;
  logic [7:0] r;

  always_comb begin
    // Subtraction is a + ~b + cin, so carry out set means no borrow.
    diff = {1'b0, u.a} + {1'b0, ~u.b} + {8'h00, u.cin};
    low = {1'b0, u.a[3:0]} + {1'b0, ~u.b[3:0]} + {4'h0, u.cin};
    case (u.op)
      cpu_slice_pkg::ALU_SUBB,
      cpu_slice_pkg::ALU_SUBW,
      cpu_slice_pkg::ALU_SUBL: r = diff[7:0];
      cpu_slice_pkg::ALU_SWAP: r = {u.a[3:0], u.a[7:4]};
      cpu_slice_pkg::ALU_XOR:  r = u.a ^ u.b;
      default:                 r = u.a;
    endcase
    u.res = r;
    u.flags = 5'h00;
    u.flags[cpu_slice_pkg::ST_C] = diff[8];
    u.flags[cpu_slice_pkg::ST_DC] = low[4];
    u.flags[cpu_slice_pkg::ST_Z] = (r == cpu_slice_pkg::BYTE_ZERO);
    u.flags[cpu_slice_pkg::ST_OV] = (u.a[7] != u.b[7]) && (r[7] != u.a[7]);
    u.flags[cpu_slice_pkg::ST_N] = r[7];
  end
endmodule // slice_alu
`default_nettype wire
